// [hw/psb_port.sv]
// Purpose: slave side of a self-refreshing psram ddr bus port
// Assumes: link_clock is the true bus clock, idle low between frames
// Notes: link framing and drive logic is held in reset while chip select is high
`timescale 1ns/100ps
module psb_port
#(
    parameter int LAT = psb_pkg::LAT_DEF,
    parameter bit DUAL_DIE = 1'b1
)
(
    // system
    input wire logic clock,
    input wire logic rstn,
    // link pins
    input wire logic link_clock,
    input wire logic clock_complement,
    input wire logic cs_n,
    input wire logic reset_pin_n,
    input wire logic [7:0] dq_i,
    output logic [7:0] dq_o,
    output logic dq_oe,
    input wire logic rw_strobe_mask_i,
    output logic rw_strobe_mask_o,
    output logic rw_strobe_mask_oe,
    // command out
    output logic cmd_valid,
    output logic [psb_pkg::CA_W-1:0] cmd_word,
    // write data out
    output logic wr_valid,
    output psb_pkg::psb_wr_type wr_word,
    // read data in
    output logic rd_req,
    input wire logic rd_valid,
    input wire logic [15:0] rd_data,
    // status
    output logic frame_end,
    output logic standby
);
    import psb_pkg::*;

    localparam int LAT_TOT = DUAL_DIE ? 2 * LAT : LAT;
    localparam int DATA_START = CA_CYCLES + 1 + LAT_TOT;
    localparam logic [CNT_W-1:0] CA_LAST = CNT_W'(CA_CYCLES);
    localparam logic [CNT_W-1:0] DATA_AT = CNT_W'(DATA_START);
    localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

    logic frame_rst_n, rd_q, pos_mask_q, strobe_oe_q, strobe_q, dq_oe_q;
    logic rd_tgl_q, cmd_tgl_q, wr_tgl_q, cmd_ev, wr_ev, rd_ev, pin_ok;
    logic [CNT_W-1:0] cyc_q, cyc_d;
    psb_phase_type phase_q, phase_d;
    logic [7:0] pos_byte_q;
    logic [15:0] rd_word_q, rd_buf_q;
    logic [CA_W-1:0] ca_q;
    psb_wr_type wr_q;
    logic [SYNC_W-1:0] sync1_q, sync2_q, prev_q;

    // ***************************************
    // link domain: framing
    // ***************************************
    // frame opens on select low
    // select high resets link framing and drive state at once
    // idle select keeps link framing and drive logic cleared
    assign frame_rst_n = reset_pin_n & ~cs_n;

    // count the three command cycles, then latency
    always_comb
    begin
        cyc_d = (cyc_q == CNT_MAX) ? cyc_q : cyc_q + 1'b1;
        if (cyc_d <= CA_LAST)
            phase_d = PH_CA;
        else if (cyc_d < DATA_AT)
            phase_d = PH_LAT;
        else
            phase_d = PH_DATA;
    end

    // only frame edges advance; no free-running clock needed
    // true clock alone times the link
    // the complement input is not used here
    always_ff @(posedge link_clock or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            cyc_q <= '0;
            phase_q <= PH_CA;
        end
        else
        begin
            cyc_q <= cyc_d;
            phase_q <= phase_d;
        end
    end

    // rising-edge capture of byte and mask
    always_ff @(posedge link_clock or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            pos_byte_q <= 8'h00;
            pos_mask_q <= 1'b0;
            rd_q <= 1'b0;
        end
        else
        begin
            // bytes carried on the data lines
            pos_byte_q <= dq_i;
            pos_mask_q <= rw_strobe_mask_i;
            if (cyc_q == '0)
                rd_q <= dq_i[RW_DQ_BIT];
        end
    end

    // ***************************************
    // link domain: strobe and read drive
    // ***************************************
    always_ff @(posedge link_clock or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            strobe_oe_q <= 1'b0;
            strobe_q <= 1'b0;
            dq_oe_q <= 1'b0;
            rd_word_q <= 16'h0000;
        end
        else
        begin
            case (phase_d)
                PH_CA:
                begin
                    // strobe is an output during command
                    // high asks for the added latency
                    strobe_oe_q <= 1'b1;
                    strobe_q <= DUAL_DIE;
                    dq_oe_q <= 1'b0;
                end
                PH_LAT:
                begin
                    strobe_oe_q <= rd_q;
                    strobe_q <= 1'b0;
                    dq_oe_q <= 1'b0;
                end
                PH_DATA:
                begin
                    // writes leave the strobe to the host
                    strobe_oe_q <= rd_q;
                    strobe_q <= 1'b0;
                    dq_oe_q <= rd_q;
                    if (rd_q)
                        rd_word_q <= rd_buf_q;
                end
                default:
                begin
                    strobe_oe_q <= 1'b0;
                    strobe_q <= 1'b0;
                    dq_oe_q <= 1'b0;
                end
            endcase
        end
    end

    // read word request toggle, one per data cycle
    always_ff @(posedge link_clock or negedge reset_pin_n)
        if (!reset_pin_n)
            rd_tgl_q <= 1'b0;
        else if (phase_d == PH_DATA && rd_q && cs_n == 1'b0)
            rd_tgl_q <= ~rd_tgl_q;

    // byte A while strobe high, byte B while low
    assign dq_o = link_clock ? rd_word_q[15:8] : rd_word_q[7:0];
    assign dq_oe = dq_oe_q;
    assign rw_strobe_mask_o = (phase_q == PH_DATA && rd_q) ? link_clock : strobe_q;
    assign rw_strobe_mask_oe = strobe_oe_q;

    // ***************************************
    // link domain: falling-edge word assembly
    // ***************************************
    // words survive select rise so the last write is kept
    always_ff @(negedge link_clock or negedge reset_pin_n)
    begin
        if (!reset_pin_n)
        begin
            ca_q <= 48'h0000_0000_0000;
            cmd_tgl_q <= 1'b0;
            wr_q <= '0;
            wr_tgl_q <= 1'b0;
        end
        else
        begin
            // six bytes over both edges of three cycles
            if (phase_q == PH_CA && cyc_q != '0)
            begin
                ca_q <= {ca_q[CA_W-17:0], pos_byte_q, dq_i};
                if (cyc_q == CA_LAST)
                    cmd_tgl_q <= ~cmd_tgl_q;
            end
            // mask bit travels with each byte
            if (phase_q == PH_DATA && !rd_q)
            begin
                wr_q <= '{data: {pos_byte_q, dq_i}, mask: {pos_mask_q, rw_strobe_mask_i}};
                wr_tgl_q <= ~wr_tgl_q;
            end
        end
    end

    // ***************************************
    // system domain: crossing
    // ***************************************
    // pull-up lives at the pad; released pin reads high
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            sync1_q <= SYNC_RST;
            sync2_q <= SYNC_RST;
        end
        else
        begin
            sync1_q <= {reset_pin_n, cs_n, rd_tgl_q, wr_tgl_q, cmd_tgl_q};
            sync2_q <= sync1_q;
        end
    end

    assign pin_ok = sync2_q[SY_RST] & prev_q[SY_RST];

    always_ff @(posedge clock)
        prev_q <= sync2_q;

    assign cmd_ev = pin_ok & (sync2_q[SY_CMD] ^ prev_q[SY_CMD]);
    assign wr_ev = pin_ok & (sync2_q[SY_WR] ^ prev_q[SY_WR]);
    assign rd_ev = pin_ok & (sync2_q[SY_RD] ^ prev_q[SY_RD]);

    // ***************************************
    // system domain: user side
    // ***************************************
    // reset pin low clears and holds the user side
    always_ff @(posedge clock)
    begin
        if (!rstn || !pin_ok)
        begin
            cmd_valid <= 1'b0;
            cmd_word <= 48'h0000_0000_0000;
            wr_valid <= 1'b0;
            wr_word <= '0;
            rd_req <= 1'b0;
            frame_end <= 1'b0;
        end
        else
        begin
            cmd_valid <= cmd_ev;
            if (cmd_ev)
                cmd_word <= ca_q;
            wr_valid <= wr_ev;
            if (wr_ev)
                wr_word <= wr_q;
            rd_req <= (cmd_ev & ca_q[RW_BIT]) | rd_ev;
            frame_end <= sync2_q[SY_CS] & ~prev_q[SY_CS];
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            standby <= 1'b0;
            rd_buf_q <= 16'h0000;
        end
        else
        begin
            // standby once the pin is released
            standby <= pin_ok;
            if (rd_valid)
                rd_buf_q <= rd_data;
        end
    end

    // ***************************************
    // checks
    // ***************************************
    a_ca_strobe_out: assert property (
        @(posedge link_clock) disable iff (!frame_rst_n)
        phase_q == PH_CA && cyc_q != '0 |-> strobe_oe_q && strobe_q == DUAL_DIE)
        else $error("strobe not driven in command phase");
    a_lat_no_data: assert property (
        @(posedge link_clock) disable iff (!frame_rst_n)
        cyc_q < DATA_AT |-> !dq_oe_q)
        else $error("data driven before doubled latency");
    a_rd_drive: assert property (
        @(posedge link_clock) disable iff (!frame_rst_n)
        phase_q == PH_DATA && rd_q |-> dq_oe_q && strobe_oe_q)
        else $error("read data phase not driven");
    a_wr_released: assert property (
        @(posedge link_clock) disable iff (!frame_rst_n)
        phase_q != PH_CA && !rd_q |-> !strobe_oe_q && !dq_oe_q)
        else $error("strobe or data driven during write");
    a_idle_hiz: assert property (
        @(posedge clock) disable iff (!rstn)
        (cs_n || !reset_pin_n) |-> !dq_oe && !rw_strobe_mask_oe)
        else $error("pins driven outside a frame");
    a_frame_end: assert property (
        @(posedge clock) disable iff (!rstn)
        $rose(sync2_q[SY_CS]) && pin_ok |=> frame_end)
        else $error("frame end not flagged");
    a_cmd_pulse: assert property (
        @(posedge clock) disable iff (!rstn)
        cmd_valid |=> !cmd_valid)
        else $error("command pulse longer than one cycle");
    a_rd_request: assert property (
        @(posedge clock) disable iff (!rstn)
        cmd_valid && cmd_word[RW_BIT] |-> rd_req)
        else $error("read command without data request");
    a_reset_quiet: assert property (
        @(posedge clock) disable iff (!rstn)
        !sync2_q[SY_RST] |=> !cmd_valid && !wr_valid && !standby)
        else $error("activity while reset pin low");
endmodule

// [hw/psb_pkg.sv]
// Purpose: shared constants and types for the psram ddr port
// Assumes: 8-bit ddr link, 48-bit command/address word
// Notes: timing counts are in link clock cycles
package psb_pkg;
    // ***************************************
    // framing
    // ***************************************
    localparam int CA_CYCLES = 3;
    localparam int CA_W = 48;
    localparam int RW_BIT = 47;
    localparam int RW_DQ_BIT = 7;
    localparam int LAT_DEF = 6;
    localparam int CNT_W = 8;
    localparam int SYNC_W = 5;
    // ***************************************
    // sync vector bit positions
    // ***************************************
    localparam int SY_CMD = 0;
    localparam int SY_WR = 1;
    localparam int SY_RD = 2;
    localparam int SY_CS = 3;
    localparam int SY_RST = 4;
    localparam logic [SYNC_W-1:0] SYNC_RST = 5'h18;
    // ***************************************
    // types
    // ***************************************
    typedef enum logic [1:0]
    {
        PH_CA = 2'b00,
        PH_LAT = 2'b01,
        PH_DATA = 2'b10
    } psb_phase_type;
    typedef struct packed
    {
        logic [15:0] data;
        logic [1:0] mask;
    } psb_wr_type;
endpackage

// [tb/psb_host.sv]
// Purpose: host controller model for the psram ddr link
// Assumes: link period 160 ns, this device has its own select
// Notes: read bytes are sampled in the middle of each half-cycle
`timescale 1ns/100ps
module psb_host
#(
    parameter int DLAT = 12
)
(
    // link pins, idle with clock low and select high
    output logic link_clock = 1'b0,
    output logic clock_complement = 1'b1,
    output logic cs_n = 1'b1,
    output logic [7:0] dq_h = 8'h00,
    output logic dq_h_oe = 1'b0,
    output logic rws_h = 1'b0,
    output logic rws_h_oe = 1'b0,
    // resolved lines
    input wire logic [7:0] dq_w,
    input wire logic rws_w
);
    logic diff_q = 1'b0;
    logic [1:0] ca_rws;
    logic [7:0] rd_b [8];
    logic rd_s [8];
    // true clock, complement crosses or is held
    task automatic half(input logic [7:0] b, input logic m, input logic dv, input logic mv);
        dq_h = b;
        dq_h_oe = dv;
        rws_h = m;
        rws_h_oe = mv;
        #40;
        link_clock = ~link_clock;
        clock_complement = diff_q ? ~link_clock : 1'b0;
        #40;
    endtask
    task automatic frame(input logic [47:0] ca, input int nw, input bit rd, input logic [63:0] wd, input logic [7:0] wm);
        int k;
        logic [15:0] w;
        logic mo;
        // own select, falls with clock low
        cs_n = 1'b0;
        #80;
        for (int c = 0; c < 3 + DLAT + nw; c++)
        begin
            k = c - 3 - DLAT;
            mo = k >= 0 && !rd;
            w = c < 3 ? ca[47 - 16 * (c % 3) -: 16] : wd[16 * (k & 3) +: 16];
            half(w[15:8], wm[2 * (k & 3) + 1], c < 3 || mo, mo);
            if (c == 1 || c == 2)
                ca_rws[c - 1] = rws_w;
            if (k >= 0)
                {rd_b[2 * k], rd_s[2 * k]} = {dq_w, rws_w};
            half(w[7:0], wm[2 * (k & 3)], c < 3 || mo, mo);
            if (k >= 0)
                {rd_b[2 * k + 1], rd_s[2 * k + 1]} = {dq_w, rws_w};
        end
        #40;
        dq_h_oe = 1'b0;
        rws_h_oe = 1'b0;
        #40;
        cs_n = 1'b1;
        #160;
    endtask
endmodule

// [tb/tb.sv]
// Purpose: self-checking bench for the psram ddr slave port
// Assumes: host model drives the link, bench plays the user side
// Notes: latency parameter reduced to keep frames short
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
    import psb_pkg::*;
    localparam int LAT = 3;
    localparam logic [63:0] RDT = 64'h0f1e_2d3c_4b5a_6978;
    logic clock, rstn, rp_low, rd_valid, dq_oe, dq_h_oe, rws_o, rws_oe, rws_h, rws_h_oe, rd_req;
    logic link_clock, clock_complement, cs_n, cmd_valid, wr_valid, frame_end, standby;
    logic [7:0] dq_o, dq_h;
    logic [15:0] rd_data;
    logic [CA_W-1:0] cmd_word, cmd_seen;
    psb_wr_type wr_word;
    psb_wr_type wr_q [$];
    int failures, n_checks, n_cmd, n_end, rd_k;
    // released reset pin is pulled high
    tri1 reset_pin_w;
    assign reset_pin_w = rp_low ? 1'b0 : 1'bz;
    wire logic [7:0] dq_w = dq_oe ? dq_o : dq_h_oe ? dq_h : (link_clock ? 8'ha5 : 8'h5a);
    wire logic rws_w = rws_oe ? rws_o : rws_h_oe ? rws_h : ~link_clock;
    psb_port #(.LAT(LAT), .DUAL_DIE(1'b1)) uut
    (
        .clock(clock), .rstn(rstn), .link_clock(link_clock), .clock_complement(clock_complement),
        .cs_n(cs_n), .reset_pin_n(reset_pin_w), .dq_i(dq_w), .dq_o(dq_o), .dq_oe(dq_oe),
        .rw_strobe_mask_i(rws_w), .rw_strobe_mask_o(rws_o), .rw_strobe_mask_oe(rws_oe),
        .cmd_valid(cmd_valid), .cmd_word(cmd_word), .wr_valid(wr_valid), .wr_word(wr_word),
        .rd_req(rd_req), .rd_valid(rd_valid), .rd_data(rd_data), .frame_end(frame_end), .standby(standby)
    );
    psb_host #(.DLAT(2 * LAT)) u_host
    (
        .link_clock(link_clock), .clock_complement(clock_complement), .cs_n(cs_n), .dq_h(dq_h),
        .dq_h_oe(dq_h_oe), .rws_h(rws_h), .rws_h_oe(rws_h_oe), .dq_w(dq_w), .rws_w(rws_w)
    );
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock)
    begin
        if (cmd_valid === 1'b1)
            cmd_seen <= cmd_word;
        if (wr_valid === 1'b1)
            wr_q.push_back(wr_word);
        n_cmd <= n_cmd + int'(cmd_valid === 1'b1);
        n_end <= n_end + int'(frame_end === 1'b1);
    end
    always @(negedge clock)
    begin
        rd_valid <= rd_req === 1'b1;
        if (rd_req === 1'b1)
            rd_data <= RDT[16 * (rd_k & 3) +: 16];
        rd_k <= rd_k + int'(rd_req === 1'b1);
    end
    task automatic finish_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wait_stby(input logic lvl);
        for (int i = 0; i < 40 && standby !== lvl; i++)
            @(negedge clock);
        `CHK("standby", lvl, standby)
        if (standby !== lvl)
            finish_test();
    endtask
    task automatic t_write(input logic [47:0] ca, input int nw, input logic [63:0] wd, input logic [7:0] wm);
        int c0, e0;
        c0 = n_cmd;
        e0 = n_end;
        wr_q.delete();
        u_host.frame(ca, nw, 1'b0, wd, wm);
        `CHK("cmd count", c0 + 1, n_cmd)
        `CHK("cmd word", ca, cmd_seen)
        `CHK("ca strobe", 2'b11, u_host.ca_rws)
        `CHK("frame end", e0 + 1, n_end)
        `CHK("wr count", nw, wr_q.size())
        for (int k = 0; k < nw; k++)
            `CHK("wr word", {wd[16 * k +: 16], wm[2 * k +: 2]}, wr_q[k])
    endtask
    task automatic t_read();
        int c0;
        c0 = n_cmd;
        rd_k = 0;
        u_host.diff_q = 1'b1;
        u_host.frame(48'h8000_0000_0102, 3, 1'b1, 64'h0000_0000_0000_0000, 8'h00);
        u_host.diff_q = 1'b0;
        `CHK("rd cmd", c0 + 1, n_cmd)
        `CHK("ca strobe rd", 2'b11, u_host.ca_rws)
        `CHK("rd oe off", 1'b0, dq_oe)
        for (int k = 0; k < 6; k++)
        begin
            `CHK("rd byte", RDT[8 * (k ^ 1) +: 8], u_host.rd_b[k])
            `CHK("rd strobe", ~k[0], u_host.rd_s[k])
        end
    endtask
    task automatic t_noise();
        int c0;
        c0 = n_cmd;
        for (int i = 0; i < 8; i++)
            u_host.half(8'hc0, 1'b1, 1'b1, 1'b1);
        u_host.dq_h_oe = 1'b0;
        u_host.rws_h_oe = 1'b0;
        repeat (8) @(negedge clock);
        `CHK("idle cmd", c0, n_cmd)
        `CHK("idle dq oe", 1'b0, dq_oe)
        `CHK("idle rws oe", 1'b0, rws_oe)
    endtask
    task automatic t_reset();
        rd_k = 0;
        fork
            u_host.frame(48'h8000_0000_0200, 2, 1'b1, 64'h0000_0000_0000_0000, 8'h00);
            begin
                #((3 + 2 * LAT + 1) * 160);
                `CHK("rd oe on", 1'b1, dq_oe)
                @(negedge clock);
                rp_low = 1'b1;
                #1;
                `CHK("rst dq oe", 1'b0, dq_oe)
                `CHK("rst rws oe", 1'b0, rws_oe)
                wait_stby(1'b0);
            end
        join
        @(negedge clock);
        rp_low = 1'b0;
        wait_stby(1'b1);
    endtask
    initial
    begin
        rstn = 1'b0;
        rp_low = 1'b0;
        rd_valid = 1'b0;
        rd_data = 16'h0000;
        failures = 0;
        n_checks = 0;
        n_cmd = 0;
        n_end = 0;
        rd_k = 0;
        repeat (4) @(negedge clock);
        // pin pulse clears the link side at power-up
        rp_low = 1'b1;
        repeat (12) @(negedge clock);
        rstn = 1'b1;
        rp_low = 1'b0;
        wait_stby(1'b1);
        t_write(48'h0000_0012_3404, 2, 64'h0000_0000_beef_1234, 8'h06);
        t_write(48'h0000_00ab_cd05, 1, 64'h0000_0000_0000_a55a, 8'h01);
        t_read();
        t_noise();
        t_write(48'h0000_0000_0007, 4, 64'h1111_2222_3333_4444, 8'hc9);
        t_reset();
        t_write(48'h0000_0000_0010, 1, 64'h0000_0000_0000_9876, 8'h02);
        finish_test();
    end
endmodule
